// ---- rtl/cfm_monitor.sv ----
// Charger fault supervisor with two-wire slave register port
// ==========================================
// Behaviour
// - Input overvoltage stops switching until it clears
// - Weak source at test stops switching, flags
// - Weak source retested every seven minutes
// - System overvoltage stops switching while present
// - System short limits converter output current
// - Battery overvoltage disables converter with hysteresis
// - Battery switch stays on during battery overvoltage
// - Ship switch off only if fitted, enabled
// - Battery overcurrent always reported; alerted unless masked
// - Input overcurrent in forward charging sets high-impedance and switch-off
// - Host or adapter reattach clears both bits
// - Disabled input overcurrent still reports, no action
// - Source mode overvoltage stops switching while high
// - Source mode undervolt: off 500ms, retry
// - Thermal limit cuts current, halves timer
// - Overtemperature shutdown until cooled by hysteresis
// - Slave address 0x6B, direction bit last
// - Registers to 0x25; beyond reads 0xFF
// - Standard and fast mode rates supported
// - Bytes MSB first; slave stretches clock
// - Receiver pulls data low on ninth clock
// - Flags set on rising edge, clear on read
// - Pointer beyond map answered with not-acknowledge
// - Bursts auto-increment across register boundaries
`timescale 1ns/1ps
module cfm_monitor import cfm_pkg::*; #(
   parameter longint RETEST_CYC = RETEST_CYC_DEF,
   parameter int OTGUV_CYC = OTGUV_CYC_DEF
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic i2c_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic adapter_present,
   input wire logic input_bus_overvolt,
   input wire logic weak_source,
   input wire logic system_overvolt,
   input wire logic system_short,
   input wire logic battery_overvolt,
   input wire logic battery_above_resume,
   input wire logic battery_overcurrent,
   input wire logic input_overcurrent,
   input wire logic source_mode_overvolt,
   input wire logic source_mode_undervolt,
   input wire logic thermal_over_limit,
   input wire logic overtemp_trip,
   input wire logic overtemp_cool,
   input wire logic forward_charging,
   input wire logic source_mode_on,
   output logic converter_switch_en,
   output logic converter_current_limit,
   output logic battery_fet_on,
   output logic external_ship_switch,
   output logic input_switch_drive_a,
   output logic input_switch_drive_b,
   output logic converter_high_impedance,
   output logic input_switch_drive_off,
   output logic [1:0] thermal_limit_setting,
   output logic charge_current_cut,
   output logic termination_disable,
   output logic safety_timer_half,
   output logic source_test_load,
   output logic host_alert_n
);
   // ==========================================
   // State
   typedef struct packed {
      cfm_src_e src;
      logic [RT_W-1:0] tmr;
      logic [UV_W-1:0] uvt;
      logic uv_off;
      logic bat_ov;
      logic tshut;
      logic ship_off;
      logic adp_d;
      logic [NEV-1:0] flt_d;
      logic [NEV-1:0] flag;
      logic [NEV-1:0] mask;
      logic [7:0] ctrl;
      logic req_seen;
      logic ack_tgl;
      logic [7:0] rdata;
   } cfm_ref_s;
   typedef struct packed {
      cfm_i2c_e st;
      logic [7:0] sr;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic rw;
      logic mack;
      logic sda_low;
      logic pend;
      logic req_tgl;
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic scl_d;
      logic sda_d;
   } cfm_link_s;
   cfm_ref_s r_reg, r_next;
   cfm_link_s l_reg, l_next;
   logic s_adp, s_vbov, s_weak, s_sysov, s_short, s_bathi, s_batlo, s_boc;
   logic s_iocp, s_otgov, s_otguv, s_thermal_limit_setting, s_trip, s_cool, s_req;
   logic s_scl, s_sda, s_ack;
   logic [NEV-1:0] fnow, evt, mask_eff, stat;
   logic adp_rise, fire, l_rise, l_fall, l_start, l_stop, l_done;
   // ==========================================
   // Crossings
   cfm_sync #(.W(15)) u_ref_sync (
      .clk(ref_clk),
      .rstn(rstn),
      .d({adapter_present, input_bus_overvolt, weak_source, system_overvolt, system_short,
          battery_overvolt, battery_above_resume, battery_overcurrent, input_overcurrent,
          source_mode_overvolt, source_mode_undervolt, thermal_over_limit, overtemp_trip,
          overtemp_cool, l_reg.req_tgl}),
      .q({s_adp, s_vbov, s_weak, s_sysov, s_short, s_bathi, s_batlo, s_boc, s_iocp,
          s_otgov, s_otguv, s_thermal_limit_setting, s_trip, s_cool, s_req})
   );
   // Link clock oversamples the bus well above fast-mode rates
   cfm_sync #(.W(3)) u_link_sync (
      .clk(i2c_clk),
      .rstn(rstn),
      .d({scl_i, sda_i, r_reg.ack_tgl}),
      .q({s_scl, s_sda, s_ack})
   );
   cfm_alert u_alert (
      .clk(ref_clk),
      .rstn(rstn),
      .fire(fire),
      .alert_n(host_alert_n)
   );
   // ==========================================
   // Register read decode
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input cfm_ref_s s, input logic [NEV-1:0] st);
      logic [15:0] f;
      logic [15:0] m;
      logic [15:0] v;
      f = 16'(s.flag);
      m = 16'(s.mask);
      v = 16'(st);
      rd_byte = 8'h00;
      if (a > REG_LAST) rd_byte = RD_BEYOND;
      else if (a == OFS_CTRL) rd_byte = s.ctrl;
      else if (a == OFS_MASK0) rd_byte = m[7:0];
      else if (a == OFS_MASK1) rd_byte = m[15:8];
      else if (a == OFS_STAT0) rd_byte = v[7:0];
      else if (a == OFS_STAT1) rd_byte = v[15:8];
      else if (a == OFS_FLAG0) rd_byte = f[7:0];
      else if (a == OFS_FLAG1) rd_byte = f[15:8];
   endfunction
   // ==========================================
   // Protection, flags and register file
   assign adp_rise = s_adp && !r_reg.adp_d;
   assign source_test_load = (r_reg.src == SRC_TEST) ||
      ((r_reg.src == SRC_POOR) && (r_reg.tmr >= RT_W'(RETEST_CYC - SRCTEST_CYC)));
   // Source mode runs from the battery, so the adapter verdict does not gate it
   assign converter_switch_en = (source_mode_on || r_reg.src == SRC_GOOD)
      && !s_vbov
      && !s_sysov
      && !r_reg.bat_ov
      && !r_reg.tshut
      && !r_reg.uv_off
      && !r_reg.ctrl[CB_HIZ]
      && !(source_mode_on && s_otgov);
   assign converter_current_limit = s_short;
   assign battery_fet_on = !converter_switch_en || r_reg.bat_ov;
   assign external_ship_switch = !r_reg.ship_off;
   assign converter_high_impedance = r_reg.ctrl[CB_HIZ];
   assign input_switch_drive_off = r_reg.ctrl[CB_ACOFF];
   assign input_switch_drive_a = !r_reg.ctrl[CB_ACOFF];
   assign input_switch_drive_b = !r_reg.ctrl[CB_ACOFF];
   assign thermal_limit_setting = r_reg.ctrl[CB_THERMAL_LIMIT_SETTING +: 2];
   assign charge_current_cut = s_thermal_limit_setting;
   assign termination_disable = s_thermal_limit_setting;
   assign safety_timer_half = s_thermal_limit_setting;
   always_comb begin
      fnow = '0;
      fnow[EV_VBOV] = s_vbov;
      fnow[EV_PG] = r_reg.src == SRC_POOR;
      fnow[EV_SYSOV] = s_sysov;
      fnow[EV_SHORT] = s_short;
      fnow[EV_BATOV] = r_reg.bat_ov;
      fnow[EV_BOC] = s_boc;
      fnow[EV_IOCP] = s_iocp;
      fnow[EV_OTGOV] = s_otgov && source_mode_on;
      fnow[EV_OTGUV] = r_reg.uv_off;
      fnow[EV_THERMAL_LIMIT_SETTING] = s_thermal_limit_setting;
      fnow[EV_TSHUT] = r_reg.tshut;
      fnow[EV_WEAK] = r_reg.src == SRC_POOR;
      stat = fnow;
      stat[EV_PG] = r_reg.src == SRC_GOOD;
      stat[EV_OTGUV] = 1'b0;
      stat[EV_WEAK] = 1'b0;
      evt = fnow & ~r_reg.flt_d;
      mask_eff = r_reg.mask;
      mask_eff[EV_WEAK] = r_reg.mask[EV_PG];
      fire = |(evt & ~mask_eff);
   end
   always_comb begin
      logic [NEV-1:0] clr;
      logic [15:0] wm;
      clr = '0;
      wm = 16'(r_reg.mask);
      r_next = r_reg;
      r_next.adp_d = s_adp;
      r_next.flt_d = fnow;
      // Adapter verdict
      unique case (r_reg.src)
         SRC_IDLE: begin
            r_next.tmr = '0;
            if (s_adp) r_next.src = SRC_TEST;
         end
         SRC_TEST: begin
            r_next.tmr = r_reg.tmr + RT_W'(1);
            if (r_reg.tmr == RT_W'(SRCTEST_CYC - 1)) begin
               r_next.tmr = '0;
               r_next.src = s_weak ? SRC_POOR : SRC_GOOD;
            end
         end
         SRC_GOOD: ;
         SRC_POOR: begin
            r_next.tmr = r_reg.tmr + RT_W'(1);
            if (r_reg.tmr == RT_W'(RETEST_CYC - 1)) begin
               r_next.tmr = '0;
               if (!s_weak) r_next.src = SRC_GOOD;
            end
         end
      endcase
      if (!s_adp) r_next.src = SRC_IDLE;
      // Comparator hysteresis held as state
      if (s_bathi) r_next.bat_ov = 1'b1;
      else if (!s_batlo) r_next.bat_ov = 1'b0;
      if (s_trip) r_next.tshut = 1'b1;
      else if (s_cool) r_next.tshut = 1'b0;
      if (r_reg.uv_off) begin
         r_next.uvt = r_reg.uvt + UV_W'(1);
         if (r_reg.uvt == UV_W'(OTGUV_CYC - 1)) r_next.uv_off = 1'b0;
      end else if (source_mode_on && converter_switch_en && s_otguv) begin
         r_next.uv_off = 1'b1;
         r_next.uvt = '0;
      end
      // Host access from the link side
      if (s_req != r_reg.req_seen) begin
         r_next.req_seen = s_req;
         r_next.ack_tgl = s_req;
         if (l_reg.we) begin
            if (l_reg.addr == OFS_CTRL) r_next.ctrl = l_reg.wdata;
            if (l_reg.addr == OFS_MASK0) wm[7:0] = l_reg.wdata;
            if (l_reg.addr == OFS_MASK1) wm[15:8] = l_reg.wdata;
            r_next.mask = wm[NEV-1:0];
         end else begin
            r_next.rdata = rd_byte(l_reg.addr, r_reg, stat);
            if (l_reg.addr == OFS_FLAG0) clr = NEV'(12'h0FF);
            if (l_reg.addr == OFS_FLAG1) clr = NEV'(12'hF00);
         end
      end
      // Hardware set wins over a read-clear in the same cycle
      r_next.flag = (r_reg.flag & ~clr) | evt;
      if (adp_rise) begin
         r_next.ctrl[CB_HIZ] = 1'b0;
         r_next.ctrl[CB_ACOFF] = 1'b0;
      end
      if (s_iocp && r_reg.ctrl[CB_IOCP_EN] && forward_charging) begin
         r_next.ctrl[CB_HIZ] = 1'b1;
         r_next.ctrl[CB_ACOFF] = 1'b1;
      end
      // Ship switch stays off until disabled by host or adapter reattached
      if (adp_rise || !r_next.ctrl[CB_BOC_EN]) r_next.ship_off = 1'b0;
      if (s_boc && r_reg.ctrl[CB_SHIP_FIT] && r_reg.ctrl[CB_BOC_EN]) r_next.ship_off = 1'b1;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
         r_reg.src <= SRC_IDLE;
         r_reg.ctrl <= CTRL_RST;
         r_reg.mask <= MASK_RST;
      end else begin
         r_reg <= r_next;
      end
   end
   // ==========================================
   // Two-wire slave on the link clock
   assign l_rise = s_scl && !l_reg.scl_d;
   assign l_fall = !s_scl && l_reg.scl_d;
   assign l_start = s_scl && l_reg.scl_d && l_reg.sda_d && !s_sda;
   assign l_stop = s_scl && l_reg.scl_d && !l_reg.sda_d && s_sda;
   assign l_done = l_reg.pend && (s_ack == l_reg.req_tgl);
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = l_reg.pend;
   assign sda_oe = l_reg.sda_low;
   always_comb begin
      l_next = l_reg;
      l_next.scl_d = s_scl;
      l_next.sda_d = s_sda;
      if (l_done) begin
         l_next.pend = 1'b0;
         if (l_reg.st == I_RD) begin
            l_next.sr = r_reg.rdata;
            l_next.ptr = l_reg.ptr + 8'h01;
            l_next.sda_low = !r_reg.rdata[7];
            l_next.cnt = 4'h0;
         end
      end
      if (l_rise && l_reg.cnt < 4'h8 && (l_reg.st == I_ADDR || l_reg.st == I_PTR || l_reg.st == I_WR)) begin
         l_next.sr = {l_reg.sr[6:0], s_sda};
         l_next.cnt = l_reg.cnt + 4'h1;
      end
      unique case (l_reg.st)
         I_IDLE: ;
         I_ADDR: if (l_fall && l_reg.cnt == 4'h8) begin
            l_next.cnt = 4'h0;
            l_next.st = I_IDLE;
            if (l_reg.sr[7:1] == SLV_ADDR) begin
               l_next.sda_low = 1'b1;
               l_next.rw = l_reg.sr[0];
               l_next.st = I_ADDR_ACK;
            end
         end
         I_ADDR_ACK: if (l_fall) begin
            l_next.sda_low = 1'b0;
            l_next.st = I_PTR;
            if (l_reg.rw) begin
               l_next.req_tgl = !l_reg.req_tgl;
               l_next.pend = 1'b1;
               l_next.we = 1'b0;
               l_next.addr = l_reg.ptr;
               l_next.st = I_RD;
            end
         end
         I_PTR: if (l_fall && l_reg.cnt == 4'h8) begin
            l_next.cnt = 4'h0;
            l_next.st = I_IDLE;
            if (l_reg.sr <= REG_LAST) begin
               l_next.ptr = l_reg.sr;
               l_next.sda_low = 1'b1;
               l_next.st = I_PTR_ACK;
            end
         end
         I_PTR_ACK, I_WR_ACK: if (l_fall) begin
            l_next.sda_low = 1'b0;
            l_next.st = I_WR;
         end
         I_WR: if (l_fall && l_reg.cnt == 4'h8) begin
            l_next.cnt = 4'h0;
            l_next.sda_low = 1'b1;
            l_next.req_tgl = !l_reg.req_tgl;
            l_next.pend = 1'b1;
            l_next.we = 1'b1;
            l_next.addr = l_reg.ptr;
            l_next.wdata = l_reg.sr;
            l_next.ptr = l_reg.ptr + 8'h01;
            l_next.st = I_WR_ACK;
         end
         I_RD: if (l_fall) begin
            l_next.cnt = l_reg.cnt + 4'h1;
            l_next.sr = {l_reg.sr[6:0], 1'b1};
            l_next.sda_low = !l_reg.sr[6];
            if (l_reg.cnt == 4'h7) begin
               l_next.sda_low = 1'b0;
               l_next.st = I_RD_ACK;
            end
         end
         I_RD_ACK: begin
            if (l_rise) l_next.mack = !s_sda;
            if (l_fall) begin
               l_next.st = I_IDLE;
               if (l_reg.mack) begin
                  l_next.req_tgl = !l_reg.req_tgl;
                  l_next.pend = 1'b1;
                  l_next.we = 1'b0;
                  l_next.addr = l_reg.ptr;
                  l_next.st = I_RD;
               end
            end
         end
         default: l_next.st = I_IDLE;
      endcase
      if (l_stop) begin
         l_next.st = I_IDLE;
         l_next.sda_low = 1'b0;
      end
      if (l_start) begin
         l_next.st = I_ADDR;
         l_next.cnt = 4'h0;
         l_next.sda_low = 1'b0;
      end
   end
   always_ff @(posedge i2c_clk or negedge rstn) begin
      if (!rstn) begin
         l_reg <= '0;
         l_reg.st <= I_IDLE;
      end else begin
         l_reg <= l_next;
      end
   end
   // ==========================================
   // Checks
   vbus_ov_stop_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_vbov |-> !converter_switch_en) else $error("switching during input overvoltage");
   weak_verdict_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (r_reg.src == SRC_TEST && r_reg.tmr == RT_W'(SRCTEST_CYC - 1) && s_weak && s_adp)
      |=> r_reg.src == SRC_POOR ##1 r_reg.flag[EV_PG] && r_reg.flag[EV_WEAK] && !converter_switch_en)
      else $error("weak source verdict missing");
   retest_good_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (r_reg.src == SRC_POOR && r_reg.tmr == RT_W'(RETEST_CYC - 1) && !s_weak && s_adp)
      |=> r_reg.src == SRC_GOOD) else $error("retest did not accept source");
   sys_ov_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(s_sysov) |-> !converter_switch_en ##1 r_reg.flag[EV_SYSOV]) else $error("system overvoltage");
   bat_ov_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (r_reg.bat_ov && s_batlo) |=> r_reg.bat_ov && battery_fet_on) else $error("battery hysteresis");
   ship_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (s_boc && !(r_reg.ctrl[CB_SHIP_FIT] && r_reg.ctrl[CB_BOC_EN]) && !r_reg.ship_off)
      |=> external_ship_switch) else $error("ship switch opened while not armed");
   iocp_hiz_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (s_iocp && r_reg.ctrl[CB_IOCP_EN] && forward_charging)
      |=> converter_high_impedance && input_switch_drive_off && !input_switch_drive_a)
      else $error("input overcurrent shutdown missing");
   tshut_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (r_reg.tshut && !s_cool) |=> r_reg.tshut && !converter_switch_en) else $error("early thermal restart");
   alert_pulse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
      (fire && host_alert_n) |-> ##[1:4] !host_alert_n) else $error("alert pulse missing");
   ptr_nack_a: assert property (@(posedge i2c_clk) disable iff (!rstn)
      (l_reg.st == I_PTR && l_fall && l_reg.cnt == 4'h8 && l_reg.sr > REG_LAST && !l_start && !l_stop)
      |=> l_reg.st == I_IDLE && !sda_oe) else $error("undefined pointer acknowledged");
   weak_seen_c: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(r_reg.src == SRC_POOR));
   otg_uv_c: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(r_reg.uv_off));
   rd_burst_c: cover property (@(posedge i2c_clk) disable iff (!rstn) l_reg.st == I_RD_ACK && l_fall && l_reg.mack);
endmodule

// ---- rtl/cfm_pkg.sv ----
// Shared constants and types for the charger fault monitor
package cfm_pkg;
   // ==========================================
   // Serial port
   localparam int CLK_MHZ = 50;
   localparam logic [6:0] SLV_ADDR = 7'h6B;
   localparam logic [7:0] REG_LAST = 8'h25;
   localparam logic [7:0] RD_BEYOND = 8'hFF;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MASK0 = 8'h01;
   localparam logic [7:0] OFS_MASK1 = 8'h02;
   localparam logic [7:0] OFS_STAT0 = 8'h03;
   localparam logic [7:0] OFS_STAT1 = 8'h04;
   localparam logic [7:0] OFS_FLAG0 = 8'h05;
   localparam logic [7:0] OFS_FLAG1 = 8'h06;
   // ==========================================
   // Control byte fields and reset values
   localparam int CB_HIZ = 0;
   localparam int CB_ACOFF = 1;
   localparam int CB_IOCP_EN = 2;
   localparam int CB_BOC_EN = 3;
   localparam int CB_SHIP_FIT = 4;
   localparam int CB_THERMAL_LIMIT_SETTING = 5;
   localparam logic [7:0] CTRL_RST = 8'h04;
   localparam logic [11:0] MASK_RST = 12'h000;
   // ==========================================
   // Fault event positions
   localparam int NEV = 12;
   localparam int EV_VBOV = 0;
   localparam int EV_PG = 1;
   localparam int EV_SYSOV = 2;
   localparam int EV_SHORT = 3;
   localparam int EV_BATOV = 4;
   localparam int EV_BOC = 5;
   localparam int EV_IOCP = 6;
   localparam int EV_OTGOV = 7;
   localparam int EV_OTGUV = 8;
   localparam int EV_THERMAL_LIMIT_SETTING = 9;
   localparam int EV_TSHUT = 10;
   localparam int EV_WEAK = 11;
   // ==========================================
   // Timing
   localparam int ALERT_NS = 1000;
   localparam int ALERT_CYC = ALERT_NS * CLK_MHZ / 1000;
   localparam int SRCTEST_US = 10;
   localparam int SRCTEST_CYC = SRCTEST_US * CLK_MHZ;
   localparam int OTGUV_MS = 500;
   localparam int OTGUV_CYC_DEF = OTGUV_MS * CLK_MHZ * 1000;
   localparam longint RETEST_MIN = 7;
   localparam longint RETEST_CYC_DEF = RETEST_MIN * 60 * CLK_MHZ * 1000000;
   localparam int RT_W = 35;
   localparam int UV_W = 25;
   localparam int AL_W = 8;
   // ==========================================
   // State encodings
   typedef enum logic [1:0] {
      SRC_IDLE = 2'h0, SRC_TEST = 2'h1, SRC_GOOD = 2'h3, SRC_POOR = 2'h2
   } cfm_src_e;
   typedef enum logic [3:0] {
      I_IDLE = 4'h0, I_ADDR = 4'h1, I_ADDR_ACK = 4'h3, I_PTR = 4'h2, I_PTR_ACK = 4'h6,
      I_WR = 4'h7, I_WR_ACK = 4'h5, I_RD = 4'h4, I_RD_ACK = 4'hC
   } cfm_i2c_e;
endpackage

// ---- rtl/cfm_sync.sv ----
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module cfm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] m;
      logic [W-1:0] q;
   } cfm_sync_s;
   cfm_sync_s s_reg, s_next;
   always_comb begin
      s_next.m = d;
      s_next.q = s_reg.m;
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) s_reg <= '0;
      else s_reg <= s_next;
   end
   assign q = s_reg.q;
endmodule

// ---- rtl/cfm_alert.sv ----
// Fixed-length active-low alert pulse generator
`timescale 1ns/1ps
module cfm_alert import cfm_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic fire,
   output logic alert_n
);
   typedef struct packed {
      logic busy;
      logic pend;
      logic low;
      logic [AL_W-1:0] cnt;
   } cfm_alert_s;
   cfm_alert_s a_reg, a_next;
   // Two idle cycles close every pulse so back-to-back events stay separate
   always_comb begin
      a_next = a_reg;
      if (fire) a_next.pend = 1'b1;
      if (a_reg.busy) begin
         if (a_reg.cnt == AL_W'(ALERT_CYC)) a_next.busy = 1'b0;
         else a_next.cnt = a_reg.cnt + 8'h01;
      end else if (a_reg.pend) begin
         a_next.busy = 1'b1;
         a_next.cnt = '0;
         a_next.pend = fire;
      end
      a_next.low = a_next.busy && (a_next.cnt < AL_W'(ALERT_CYC));
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) a_reg <= '0;
      else a_reg <= a_next;
   end
   assign alert_n = !a_reg.low;
endmodule

// ---- tb/cfm_i2c_master.sv ----
// Two-wire bus master model for the slave port
`timescale 1ns/1ps
module cfm_i2c_master (
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   // ==========
   // Bit timing
   localparam int H = 1250;
   int stalls = 0;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // Start or repeated start; data moves with clock low
   task automatic start();
      sda_oe = 1'b0;
      #H;
      scl_oe = 1'b0;
      #H;
      sda_oe = 1'b1;
      #H;
      scl_oe = 1'b1;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #H;
      scl_oe = 1'b0;
      #H;
      sda_oe = 1'b0;
      #H;
   endtask
   // Bounded wait while the slave stretches
   task automatic bit_x(input logic b, output logic r);
      sda_oe = ~b;
      #H;
      scl_oe = 1'b0;
      for (int i = 0; i < 400 && scl !== 1'b1; i++) #100;
      if (scl !== 1'b1) stalls++; // Stuck stretch counts as a mismatch
      #H;
      r = sda;
      scl_oe = 1'b1;
   endtask
   task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(l, a);
   endtask
endmodule

// ---- tb/cfm_monitor_tb_top.sv ----
// Self-checking bench for the charger fault monitor
`timescale 1ns/1ps
module cfm_monitor_tb_top import cfm_pkg::*;;
   logic ref_clk = 1'b0;
   logic i2c_clk = 1'b0;
   logic rstn = 1'b0;
   logic [12:0] ci = '0;
   logic scl_oe, sda_oe, m_scl, m_sda, ack, m, swen, clim, ship, dra, hiz, doff, cut, half, al_n, fet, drb, term;
   logic [7:0] q;
   logic [7:0] rb [2];
   int error_cnt = 0;
   int checked = 0;
   wire scl = ~(m_scl | scl_oe);
   wire sda = ~(m_sda | sda_oe);
   initial forever #10 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #15 i2c_clk = ~i2c_clk;
   end
   cfm_monitor #(.RETEST_CYC(2000), .OTGUV_CYC(200)) cfm_monitor_i (.ref_clk, .rstn, .i2c_clk, .scl_i(scl),
      .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .adapter_present(ci[0]), .input_bus_overvolt(ci[1]),
      .weak_source(ci[2]), .system_overvolt(ci[3]), .system_short(ci[4]), .battery_overvolt(ci[5]),
      .battery_above_resume(ci[6]), .battery_overcurrent(ci[7]), .input_overcurrent(ci[8]),
      .source_mode_overvolt(1'b0), .source_mode_undervolt(1'b0), .thermal_over_limit(ci[9]), .overtemp_trip(ci[11]),
      .overtemp_cool(ci[12]), .forward_charging(ci[10]), .source_mode_on(1'b0), .converter_switch_en(swen),
      .converter_current_limit(clim), .battery_fet_on(fet), .external_ship_switch(ship), .input_switch_drive_a(dra),
      .input_switch_drive_b(drb), .converter_high_impedance(hiz), .input_switch_drive_off(doff),
      .thermal_limit_setting(), .charge_current_cut(cut), .termination_disable(term), .safety_timer_half(half),
      .source_test_load(), .host_alert_n(al_n));
   cfm_i2c_master cfm_i2c_master_i (.scl, .sda, .scl_oe(m_scl), .sda_oe(m_sda));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic summarize();
      error_cnt += cfm_i2c_master_i.stalls;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic xa(input logic [7:0] p, input int n, input logic r);
      cfm_i2c_master_i.start();
      cfm_i2c_master_i.xfer({SLV_ADDR, 1'b0}, 1'b1, q, ack);
      chk("adr ack", 0, ack);
      cfm_i2c_master_i.xfer(p, 1'b1, q, ack);
      chk("ptr ack", p > REG_LAST, ack);
      if (r) begin
         cfm_i2c_master_i.start();
         cfm_i2c_master_i.xfer({SLV_ADDR, 1'b1}, 1'b1, q, ack);
      end
      for (int i = 0; i < n; i++) cfm_i2c_master_i.xfer(r ? 8'hFF : rb[i], r ? i == n - 1 : 1'b1, rb[i], ack);
      cfm_i2c_master_i.stop();
      @(negedge ref_clk);
   endtask
   task automatic alert_len(input logic [7:0] e);
      int n = 0;
      for (int i = 0; i < 20 && al_n; i++) @(negedge ref_clk);
      for (int i = 0; i < 200 && !al_n; i++) begin
         n++;
         @(negedge ref_clk);
      end
      chk("alert", e, n[7:0]);
   endtask
   initial begin
      void'($urandom(88));
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      ci[0] = 1'b1;
      xa(OFS_CTRL, 2, 1);
      chk("ctrl", CTRL_RST, rb[0]);
      chk("mask", 0, rb[1]);
      chk("swen", 1, swen);
      for (int k = 0; k < 4; k++) begin
         m = 1'($urandom_range(1, 0));
         rb[0] = {7'h00, m};
         xa(OFS_MASK0, 1, 0);
         ci[1] = 1'b1;
         alert_len(m ? 8'h00 : 8'(ALERT_CYC));
         chk("swen ov", 0, swen);
         ci[1] = 1'b0;
         repeat (4) @(negedge ref_clk);
         chk("swen back", 1, swen);
      end
      xa(OFS_FLAG0, 1, 1);
      chk("flag", 8'h01, rb[0]);
      xa(OFS_FLAG0, 1, 1);
      chk("flag clr", 0, rb[0]);
      ci[10] = 1'b1;
      ci[8] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("hiz", 8'h03, {6'h00, hiz, doff});
      chk("drv", 0, {dra, drb});
      ci[8] = 1'b0;
      rb[0] = CTRL_RST;
      xa(OFS_CTRL, 1, 0);
      chk("drv on", 3, {dra, drb});
      rb[0] = 8'h1C;
      xa(OFS_CTRL, 1, 0);
      ci[7] = 1'b1;
      ci[9] = 1'b1;
      ci[4] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("ship", 0, ship);
      chk("thermal_limit_setting", 7, {cut, half, term});
      chk("short", 1, clim);
      ci[3] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("sys ov", 0, swen);
      ci[3] = 1'b0;
      ci[5] = 1'b1;
      ci[6] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("bat ov", 8'h02, {6'h00, fet, swen});
      ci[5] = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("bat hyst", 8'h02, {6'h00, fet, swen});
      ci[6] = 1'b0;
      ci[11] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("tshut", 0, swen);
      ci[11] = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("tshut hold", 0, swen);
      ci[12] = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk("tshut end", 8'h01, {6'h00, fet, swen});
      ci[0] = 1'b0;
      ci[2] = 1'b1;
      repeat (4) @(negedge ref_clk);
      ci[0] = 1'b1;
      repeat (600) @(negedge ref_clk);
      chk("weak", 0, swen);
      ci[2] = 1'b0;
      repeat (2100) @(negedge ref_clk);
      chk("retest", 1, swen);
      xa(OFS_FLAG0, 1, 1);
      chk("flags", 8'h7E, rb[0]);
      xa(REG_LAST, 2, 1);
      chk("last", 0, rb[0]);
      chk("beyond", RD_BEYOND, rb[1]);
      xa(8'h26, 0, 0);
      summarize();
   end
endmodule
